// file: shared/cpu_core_regs.svh
/*
 * Timing counts, cycle counts, lengths and reset values of the execution core.
 * Assumes the including file follows it with the type package.
 */
`ifndef CPU_CORE_REGS_SVH
`define CPU_CORE_REGS_SVH

// ------------------------------------------------------------
// memory sizes
// ------------------------------------------------------------
`define INTERNAL_RAM_BYTES 2048
`define STACK_BYTES 2048
`define SP_RESET 16'h0800

// ------------------------------------------------------------
// instruction cycle against the reference clock
// ------------------------------------------------------------
`define INSTR_CYCLE_PS 31250
`define CLK_PERIOD_PS 100000
`define INSTR_CLKS ((`INSTR_CYCLE_PS / `CLK_PERIOD_PS) > 0 ? \
	(`INSTR_CYCLE_PS / `CLK_PERIOD_PS) : 1)

// ------------------------------------------------------------
// instruction cycles per class
// ------------------------------------------------------------
`define CYC_SINGLE 5'h01
`define CYC_BRANCH 5'h02
`define CYC_MULTIPLY 5'h05
`define CYC_DIVIDE 5'h0A
`define CYC_STACK2 5'h02

// ------------------------------------------------------------
// encoded lengths in bytes
// ------------------------------------------------------------
`define LEN_SHORT 3'h2
`define LEN_LONG 3'h4

`endif

// file: shared/cpu_core_pkg.sv
/*
 * Operation codes and the pipeline stage record of the execution core.
 * Assumes the fetch logic outside delivers already decoded operations.
 */
package cpu_core_pkg;

	typedef enum logic [5:0] {
		op_nop, op_add, op_add_carry, op_sub, op_sub_carry,
		op_and, op_or, op_xor, op_shift_left, op_shift_right,
		op_rotate_left, op_rotate_right, op_arith_shift_right,
		op_word_multiply, op_word_multiply_u, op_divide, op_move,
		op_byte_move_sign_extend, op_byte_move_zero_extend,
		op_bit_set, op_bit_clear, op_bit_and, op_bit_or, op_bit_xor,
		op_bit_move, op_bit_compare, op_jump, op_jump_clear_bit,
		op_jump_set_bit, op_compare_decrement, op_compare_increment,
		op_normalize_count, op_context_switch, op_return_and_pop,
		op_multiply_accumulate, op_power_down_entry
	} op_t;

	typedef struct packed {
		logic valid;
		op_t op;
		logic [3:0] dst;
		logic [3:0] src;
		logic [3:0] bit_a;
		logic [3:0] bit_b;
		logic [15:0] imm;
		logic [15:0] pc;
		logic long_form;
		logic byte_mode;
		logic step_two;
		logic cond;
	} stage_t;

endpackage

// file: logic/cpu_core_exec.sv
/*
 * Execution core: three-stage pipeline, ALU, register bank and stack in
 * internal RAM, jump cache, operand feed to the multiply-accumulate unit.
 * Assumes decoded operations arrive from fetch logic on ref_clk.
 */
// What this block does
// - Three pipeline stages feed a 16-bit ALU.
// - Shifts, rotates and most instructions take one instruction cycle.
// - Branches two cycles, multiply five cycles, divide ten cycles.
// - Jump cache cuts a repeated jump to one cycle.
// - Sixteen word registers live in internal RAM, not flip-flops.
// - Context pointer gives the register bank base address.
// - Banks may overlap; count limited only by RAM size.
// - Stack of up to 2048 bytes in RAM, via stack pointer.
// - Each push compares pointer with upper limit, each pop with lower limit.
// - Up to two operands go to the coprocessor per cycle.
// - Coprocessor feed has multiply-accumulate and repeat function.
// - Coprocessor instructions are four bytes long.
// - Add, subtract and carry forms are two or four bytes.
// - Register by register multiply gives 16 by 16 product, two bytes.
// - Bit logic, compare, move four bytes; bit set, clear two.
// - Jump-clear-bit clears set bit; jump-set-bit sets clear bit.
// - Compare then decrement or increment register by one or two.
// - Normalize count writes shift count into another register.
// - Context switch pushes register then loads it; four bytes.
// - Return-and-pop returns and restores a popped register.
// - Byte to word moves sign-extend or zero-extend the low byte.
// - Arithmetic shift right keeps the sign bit; two bytes.
`timescale 1ns/1ns
`include "cpu_core_regs.svh"

module cpu_core_exec import cpu_core_pkg::*; #(
	parameter int RAM_BYTES = `INTERNAL_RAM_BYTES,
	parameter int STACK_BYTES = `STACK_BYTES
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic instr_valid,
	input wire op_t instr_op,
	input wire logic [3:0] instr_dst,
	input wire logic [3:0] instr_src,
	input wire logic [3:0] instr_bit_a,
	input wire logic [3:0] instr_bit_b,
	input wire logic [15:0] instr_imm,
	input wire logic [15:0] instr_pc,
	input wire logic instr_long,
	input wire logic instr_byte,
	input wire logic instr_step_two,
	input wire logic instr_cond,
	input wire logic [15:0] context_pointer,
	input wire logic [15:0] stack_upper_limit,
	input wire logic [15:0] stack_lower_limit,
	input wire logic nmi_n,
	output logic instr_ready,
	output logic [2:0] instr_len_bytes,
	output logic jump_taken,
	output logic [15:0] jump_target,
	output logic jump_cache_hit,
	output logic retire,
	output logic [15:0] result,
	output logic [15:0] product_high,
	output logic carry,
	output logic zero,
	output logic [15:0] stack_pointer,
	output logic stack_overflow_trap,
	output logic stack_underflow_trap,
	output logic mac_valid,
	output logic [15:0] mac_op_a,
	output logic [15:0] mac_op_b,
	output logic power_down_req
);
	localparam int AW = $clog2(RAM_BYTES) - 1;

	generate
		if (RAM_BYTES < 64 || (RAM_BYTES & (RAM_BYTES - 1)) != 0 ||
			RAM_BYTES > 65536 || STACK_BYTES > RAM_BYTES) begin : g_bad
			$error("cpu_core_exec: unsupported RAM or stack size");
		end
	endgenerate

	// ------------------------------------------------------------
	// decode functions
	// ------------------------------------------------------------
	function automatic logic [2:0] instr_len(input op_t op, input logic lf);
		case (op)
			op_add, op_add_carry, op_sub, op_sub_carry, op_and, op_or,
			op_xor, op_move, op_byte_move_sign_extend,
			op_byte_move_zero_extend, op_compare_decrement,
			op_compare_increment:
				instr_len = lf ? `LEN_LONG : `LEN_SHORT;
			op_bit_and, op_bit_or, op_bit_xor, op_bit_move,
			op_bit_compare, op_jump, op_jump_clear_bit, op_jump_set_bit,
			op_context_switch, op_power_down_entry:
				instr_len = `LEN_LONG;
			op_multiply_accumulate:
				instr_len = `LEN_LONG;
			default:
				instr_len = `LEN_SHORT;
		endcase
	endfunction

	function automatic logic [4:0] lead_zeros(input logic [15:0] v);
		logic [4:0] n;
		logic seen;
		n = 5'h00;
		seen = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			if (v[i])
				seen = 1'b1;
			else if (!seen)
				n = n + 5'h01;
		end
		if (!seen)
			n = 5'h00;
		return n;
	endfunction

	function automatic logic [AW-1:0] bank_word(input logic [15:0] base,
		input logic [3:0] idx);
		return base[AW:1] + AW'(idx);
	endfunction

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [15:0] ram_q [RAM_BYTES/2];
	stage_t pipe_q [3];
	logic [4:0] cnt_q;
	logic [15:0] sp_q;
	logic [15:0] ip_q;
	logic jc_valid_q;
	logic [15:0] jc_pc_q;
	logic [15:0] jc_tgt_q;
	logic nmi_meta_q;
	logic nmi_sync_q;

	// ------------------------------------------------------------
	// execute stage operands
	// ------------------------------------------------------------
	stage_t ex;
	logic is_mac;
	logic [3:0] idx_a;
	logic [3:0] idx_b;
	logic [15:0] a;
	logic [15:0] b_reg;
	logic [15:0] b;
	logic [15:0] pop_data;
	logic bit_a_v;
	logic bit_b_v;
	assign ex = pipe_q[2];
	assign is_mac = ex.op == op_multiply_accumulate;
	assign idx_a = ex.dst + (is_mac ? cnt_q[3:0] : 4'h0);
	assign idx_b = ex.src + (is_mac ? cnt_q[3:0] : 4'h0);
	assign a = ram_q[bank_word(context_pointer, idx_a)];
	assign b_reg = ram_q[bank_word(context_pointer, idx_b)];
	assign b = ex.long_form ? ex.imm : b_reg;
	assign pop_data = ram_q[sp_q[AW:1]];
	assign bit_a_v = a[ex.bit_a];
	assign bit_b_v = b_reg[ex.bit_b];

	// ------------------------------------------------------------
	// jump decision and cycle count
	// ------------------------------------------------------------
	logic taken;
	logic cache_hit;
	logic [4:0] need;
	assign taken = (ex.op == op_jump && ex.cond) ||
		(ex.op == op_jump_clear_bit && bit_a_v) ||
		(ex.op == op_jump_set_bit && !bit_a_v) ||
		ex.op == op_return_and_pop;
	assign cache_hit = taken && ex.op != op_return_and_pop &&
		jc_valid_q && jc_pc_q == ex.pc && jc_tgt_q == ex.imm;

	always_comb begin
		case (ex.op)
			op_jump, op_jump_clear_bit, op_jump_set_bit:
				need = cache_hit ? `CYC_SINGLE : `CYC_BRANCH;
			op_word_multiply, op_word_multiply_u:
				need = `CYC_MULTIPLY;
			op_divide:
				need = `CYC_DIVIDE;
			op_context_switch, op_return_and_pop:
				need = `CYC_STACK2;
			op_multiply_accumulate:
				need = {1'b0, ex.imm[3:0]} + 5'h01;
			default:
				need = `CYC_SINGLE;
		endcase
		need = 5'(need * `INSTR_CLKS);
	end

	logic ex_done;
	logic redirect;
	logic adv;
	assign ex_done = ex.valid && cnt_q == need - 5'h01;
	assign redirect = ex_done && taken;
	assign adv = !ex.valid || ex_done;
	assign instr_ready = adv && !redirect && !jump_taken;

	// ------------------------------------------------------------
	// ALU
	// ------------------------------------------------------------
	logic [16:0] sum;
	logic [16:0] diff;
	logic [31:0] prod;
	logic [31:0] dividend;
	logic [15:0] step;
	logic [15:0] res;
	logic res_wr;
	logic res_flags;
	logic res_c;
	logic [15:0] res_hi;
	logic hi_wr;
	assign sum = {1'b0, a} + {1'b0, b} +
		{16'h0000, ex.op == op_add_carry && carry};
	assign diff = {1'b0, a} - {1'b0, b} -
		{16'h0000, ex.op == op_sub_carry && carry};
	// operands widened first so the signed product keeps its high word
	assign prod = ex.op == op_word_multiply_u ? a * b_reg :
		32'($signed({{16{a[15]}}, a}) *
		$signed({{16{b_reg[15]}}, b_reg}));
	assign dividend = {product_high, a};
	assign step = ex.step_two ? 16'h0002 : 16'h0001;

	always_comb begin
		res = a;
		res_wr = 1'b1;
		res_flags = 1'b1;
		res_c = carry;
		res_hi = product_high;
		hi_wr = 1'b0;
		case (ex.op)
			op_add, op_add_carry: begin
				res = sum[15:0];
				res_c = ex.byte_mode ? sum[8] : sum[16];
			end
			op_sub, op_sub_carry: begin
				res = diff[15:0];
				res_c = ex.byte_mode ? diff[8] : diff[16];
			end
			op_and: res = a & b;
			op_or: res = a | b;
			op_xor: res = a ^ b;
			op_shift_left: res = a << b[3:0];
			op_shift_right: res = a >> b[3:0];
			op_rotate_left: res = 16'(({a, a} << b[3:0]) >> 16);
			op_rotate_right: res = 16'({a, a} >> b[3:0]);
			op_arith_shift_right: res = $signed(a) >>> b[3:0];
			op_word_multiply, op_word_multiply_u: begin
				res = prod[15:0];
				res_hi = prod[31:16];
				hi_wr = 1'b1;
			end
			op_divide: begin
				res = b_reg == 16'h0000 ? 16'hFFFF :
					16'(dividend / {16'h0000, b_reg});
				res_hi = b_reg == 16'h0000 ? a :
					16'(dividend % {16'h0000, b_reg});
				hi_wr = 1'b1;
			end
			op_move: res = b;
			op_byte_move_sign_extend: res = {{8{b[7]}}, b[7:0]};
			op_byte_move_zero_extend: res = {8'h00, b[7:0]};
			op_bit_set: res = a | (16'h0001 << ex.bit_a);
			op_bit_clear: res = a & ~(16'h0001 << ex.bit_a);
			op_bit_and, op_bit_or, op_bit_xor, op_bit_move: begin
				res = a & ~(16'h0001 << ex.bit_a);
				case (ex.op)
					op_bit_and: res[ex.bit_a] = bit_a_v & bit_b_v;
					op_bit_or: res[ex.bit_a] = bit_a_v | bit_b_v;
					op_bit_xor: res[ex.bit_a] = bit_a_v ^ bit_b_v;
					default: res[ex.bit_a] = bit_b_v;
				endcase
			end
			op_bit_compare: begin
				res_wr = 1'b0;
				res = {15'h0000, bit_a_v ^ bit_b_v};
				res_c = bit_a_v;
			end
			op_jump_clear_bit: begin
				res[ex.bit_a] = 1'b0;
				res_wr = bit_a_v;
				res_flags = 1'b0;
			end
			op_jump_set_bit: begin
				res[ex.bit_a] = 1'b1;
				res_wr = !bit_a_v;
				res_flags = 1'b0;
			end
			op_compare_decrement, op_compare_increment: begin
				res = ex.op == op_compare_decrement ? a - step : a + step;
				res_c = diff[16];
			end
			op_normalize_count:
				res = {11'h000, lead_zeros(b_reg)};
			op_context_switch: begin
				res = b;
				res_flags = 1'b0;
			end
			op_return_and_pop: begin
				res = pop_data;
				res_flags = 1'b0;
			end
			default: begin
				res_wr = 1'b0;
				res_flags = 1'b0;
			end
		endcase
		if (ex.byte_mode && ex.op inside {op_add, op_add_carry, op_sub,
			op_sub_carry, op_and, op_or, op_xor, op_move})
			res = {a[15:8], res[7:0]};
	end

	logic cmp_op;
	logic res_z;
	assign cmp_op = ex.op inside {op_compare_decrement, op_compare_increment};
	assign res_z = cmp_op ? a == b : ex.op == op_bit_compare ?
		res[0] == 1'b0 : res == 16'h0000;

	// ------------------------------------------------------------
	// stack access and single RAM write port
	// ------------------------------------------------------------
	logic push_now;
	logic pop_now;
	logic [15:0] sp_push;
	logic [15:0] sp_pop;
	logic ram_we;
	logic [AW-1:0] ram_addr;
	logic [15:0] ram_wdata;
	assign push_now = ex.valid && ex.op == op_context_switch &&
		cnt_q == 5'h00;
	assign pop_now = ex.valid && ex.op == op_return_and_pop;
	assign sp_push = sp_q - 16'h0002;
	assign sp_pop = sp_q + 16'h0002;
	assign ram_we = push_now || (ex_done && res_wr);
	assign ram_addr = push_now ? sp_push[AW:1] :
		bank_word(context_pointer, ex.dst);
	assign ram_wdata = push_now ? a : res;

	always_ff @(posedge ref_clk) begin
		if (ram_we)
			ram_q[ram_addr] <= ram_wdata;
	end

	// ------------------------------------------------------------
	// pipeline stages
	// ------------------------------------------------------------
	stage_t in_stage;
	always_comb begin
		in_stage.valid = instr_valid && instr_ready;
		in_stage.op = instr_op;
		in_stage.dst = instr_dst;
		in_stage.src = instr_src;
		in_stage.bit_a = instr_bit_a;
		in_stage.bit_b = instr_bit_b;
		in_stage.imm = instr_imm;
		in_stage.pc = instr_pc;
		in_stage.long_form = instr_long;
		in_stage.byte_mode = instr_byte;
		in_stage.step_two = instr_step_two;
		in_stage.cond = instr_cond;
	end

	genvar s;
	generate
		for (s = 0; s < 3; s++) begin : g_pipe
			always_ff @(posedge ref_clk or negedge arst_n) begin
				if (!arst_n)
					pipe_q[s] <= '0;
				else if (adv) begin
					if (s == 0)
						pipe_q[s] <= redirect ? '0 : in_stage;
					else
						pipe_q[s] <= redirect ? '0 :
							pipe_q[s == 0 ? 0 : s - 1];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// execute state
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= 5'h00;
			sp_q <= `SP_RESET;
			ip_q <= 16'h0000;
			jc_valid_q <= 1'b0;
			jc_pc_q <= 16'h0000;
			jc_tgt_q <= 16'h0000;
			instr_len_bytes <= 3'h0;
			jump_taken <= 1'b0;
			jump_target <= 16'h0000;
			jump_cache_hit <= 1'b0;
			retire <= 1'b0;
			result <= 16'h0000;
			product_high <= 16'h0000;
			carry <= 1'b0;
			zero <= 1'b0;
			stack_overflow_trap <= 1'b0;
			stack_underflow_trap <= 1'b0;
			mac_valid <= 1'b0;
			mac_op_a <= 16'h0000;
			mac_op_b <= 16'h0000;
			power_down_req <= 1'b0;
			nmi_meta_q <= 1'b1;
			nmi_sync_q <= 1'b1;
		end else begin
			nmi_meta_q <= nmi_n;
			nmi_sync_q <= nmi_meta_q;
			cnt_q <= adv ? 5'h00 : cnt_q + 5'h01;
			if (in_stage.valid)
				instr_len_bytes <= instr_len(instr_op, instr_long);
			retire <= ex_done;
			jump_taken <= redirect;
			jump_cache_hit <= redirect && cache_hit;
			if (redirect)
				jump_target <= ex.op == op_return_and_pop ? ip_q : ex.imm;
			if (redirect && ex.op != op_return_and_pop && !cache_hit) begin
				jc_valid_q <= 1'b1;
				jc_pc_q <= ex.pc;
				jc_tgt_q <= ex.imm;
			end
			if (pop_now && cnt_q == 5'h00)
				ip_q <= pop_data;
			if (push_now)
				sp_q <= sp_push;
			else if (pop_now)
				sp_q <= sp_pop;
			stack_overflow_trap <= push_now &&
				sp_push < stack_upper_limit;
			stack_underflow_trap <= pop_now &&
				sp_pop > stack_lower_limit;
			if (ex_done && res_wr)
				result <= res;
			if (ex_done && hi_wr)
				product_high <= res_hi;
			if (ex_done && res_flags) begin
				carry <= res_c;
				zero <= res_z;
			end
			mac_valid <= ex.valid && is_mac;
			if (ex.valid && is_mac) begin
				mac_op_a <= a;
				mac_op_b <= b;
			end
			if (ex_done && ex.op == op_power_down_entry && !nmi_sync_q)
				power_down_req <= 1'b1;
		end
	end

	assign stack_pointer = sp_q;

endmodule

// file: tb/cpu_core_exec_properties.sv
/*
 * Port properties of the execution core.
 * Assumes it is bound onto cpu_core_exec and sees only its ports.
 */
`timescale 1ns/1ns
module cpu_core_exec_chk import cpu_core_pkg::*; (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic instr_valid,
	input wire op_t instr_op,
	input wire logic instr_long,
	input wire logic instr_ready,
	input wire logic [2:0] instr_len_bytes,
	input wire logic jump_taken,
	input wire logic jump_cache_hit,
	input wire logic retire,
	input wire logic [15:0] stack_pointer,
	input wire logic [15:0] stack_upper_limit,
	input wire logic stack_overflow_trap,
	input wire logic stack_underflow_trap
);
	wire take = instr_valid && instr_ready;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// --------------------
	// properties
	// --------------------
	a_sp_reset_val: assert property (
		$rose(arst_n) |-> stack_pointer == 16'h0800)
		else $error("stack pointer wrong after reset");
	a_len_mac_four: assert property (
		take && instr_op == op_multiply_accumulate |=> instr_len_bytes == 3'h4)
		else $error("coprocessor op length not four");
	a_len_short_ops: assert property (
		take && instr_op inside {op_arith_shift_right, op_word_multiply,
		op_bit_set, op_bit_clear} |=> instr_len_bytes == 3'h2)
		else $error("short op length not two");
	a_len_bit_long: assert property (
		take && instr_op inside {op_bit_and, op_bit_or, op_bit_xor,
		op_bit_move, op_bit_compare, op_context_switch,
		op_jump_clear_bit} |=> instr_len_bytes == 3'h4)
		else $error("long op length not four");
	a_len_arith_form: assert property (
		take && instr_op inside {op_add, op_add_carry, op_sub, op_sub_carry}
		|=> instr_len_bytes == ($past(instr_long) ? 3'h4 : 3'h2))
		else $error("arithmetic op length wrong");
	a_hit_with_jump: assert property (
		jump_cache_hit |-> jump_taken && retire)
		else $error("cache hit without jump");
	a_jump_refuse_two: assert property (
		jump_taken |-> !instr_ready && $past(!instr_ready))
		else $error("op accepted during jump");
	a_trap_one_cycle: assert property (
		stack_overflow_trap || stack_underflow_trap
		|=> !stack_overflow_trap && !stack_underflow_trap)
		else $error("trap longer than one cycle");
	a_overflow_cause: assert property (
		stack_overflow_trap |-> stack_pointer < stack_upper_limit)
		else $error("overflow trap without cause");
endmodule

bind cpu_core_exec cpu_core_exec_chk cpu_core_exec_chk_i (.ref_clk, .arst_n,
	.instr_valid, .instr_op, .instr_long, .instr_ready, .instr_len_bytes,
	.jump_taken, .jump_cache_hit, .retire, .stack_pointer,
	.stack_upper_limit, .stack_overflow_trap, .stack_underflow_trap);

// file: tb/mac_copro_model.sv
/*
 * Coprocessor model: takes operand pairs and accumulates them.
 * Assumes pairs arrive as one-cycle pulses on ref_clk.
 */
`timescale 1ns/1ns
module mac_copro_model (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic mac_valid,
	input wire logic [15:0] mac_op_a,
	input wire logic [15:0] mac_op_b,
	output logic [7:0] pair_cnt_q,
	output logic [31:0] acc_q
);
	// both operands of a pair are taken in the same cycle
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pair_cnt_q <= 8'h00;
			acc_q <= 32'h0;
		end else if (mac_valid) begin
			pair_cnt_q <= pair_cnt_q + 8'h01;
			acc_q <= acc_q + mac_op_a * mac_op_b;
		end
	end
endmodule

// file: tb/cpu_core_exec_tb.sv
/*
 * Self-checking bench of the execution core.
 * Assumes the coprocessor model and the bound properties checker.
 */
`timescale 1ns/1ns
module cpu_core_exec_tb import cpu_core_pkg::*;;
	logic ref_clk = 1'b0, arst_n = 1'b0, instr_valid = 1'b0, nmi_n = 1'b1;
	logic instr_long = 1'b0, instr_byte = 1'b0, instr_step_two = 1'b0;
	logic instr_cond = 1'b0;
	op_t instr_op = op_nop;
	logic [3:0] instr_dst = 4'h0, instr_src = 4'h0, d, s;
	logic [3:0] instr_bit_a = 4'h4, instr_bit_b = 4'h0;
	logic [15:0] instr_imm = 16'h0, instr_pc = 16'h0;
	logic [15:0] context_pointer = 16'h0200;
	logic [15:0] stack_upper_limit = 16'h07FE, stack_lower_limit = 16'h07FE;
	logic instr_ready, jump_taken, jump_cache_hit, retire, carry, zero;
	logic stack_overflow_trap, stack_underflow_trap, mac_valid, power_down_req;
	logic [2:0] instr_len_bytes;
	logic [15:0] jump_target, result, product_high, stack_pointer;
	logic [15:0] mac_op_a, mac_op_b, v, w, rf [16];
	logic [31:0] p;
	logic [7:0] pair_cnt_q;
	logic [16:0] eq [$], jq [$];
	int dq [$], cyc = 0, error_cnt = 0, compares = 0, ovc = 0, unc = 0, k;
	op_t ops [12] = '{op_add, op_sub, op_and, op_or, op_xor, op_shift_left,
		op_shift_right, op_rotate_left, op_arith_shift_right,
		op_byte_move_sign_extend, op_byte_move_zero_extend, op_normalize_count};

	cpu_core_exec cpu_core_exec_i (.ref_clk, .arst_n, .instr_valid, .instr_op,
		.instr_dst, .instr_src, .instr_bit_a, .instr_bit_b, .instr_imm,
		.instr_pc, .instr_long, .instr_byte, .instr_step_two, .instr_cond,
		.context_pointer, .stack_upper_limit, .stack_lower_limit, .nmi_n,
		.instr_ready, .instr_len_bytes, .jump_taken, .jump_target,
		.jump_cache_hit, .retire, .result, .product_high, .carry, .zero,
		.stack_pointer, .stack_overflow_trap, .stack_underflow_trap,
		.mac_valid, .mac_op_a, .mac_op_b, .power_down_req);
	mac_copro_model mac_copro_model_i (.ref_clk, .arst_n, .mac_valid,
		.mac_op_a, .mac_op_b, .pair_cnt_q, .acc_q());

	always #50 ref_clk = ~ref_clk;

	// --------------------
	// helpers
	// --------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		compares++;
		if (seen !== want) begin
			error_cnt++;
			$display("wrong value at %0t: %h not %h", $time, seen, want);
		end
	endtask

	task automatic report_and_stop;
		if (error_cnt == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	function automatic logic [15:0] alu(op_t o, logic [15:0] a,
		logic [15:0] b);
		case (o)
			op_add: return a + b;
			op_sub: return a - b;
			op_and: return a & b;
			op_or: return a | b;
			op_xor: return a ^ b;
			op_shift_left: return a << b[3:0];
			op_shift_right: return a >> b[3:0];
			op_rotate_left: return (a << b[3:0]) | (a >> (5'h10 - b[3:0]));
			op_arith_shift_right: return $signed(a) >>> b[3:0];
			op_byte_move_sign_extend: return {{8{b[7]}}, b[7:0]};
			op_byte_move_zero_extend: return {8'h00, b[7:0]};
			default: begin
				for (int i = 0; i < 16; i++)
					if (b[15 - i])
						return 16'(i);
				return 16'h0;
			end
		endcase
	endfunction

	task automatic issue(input op_t o, input logic [3:0] dd,
		input logic [3:0] ss, input logic [15:0] im, input logic l,
		input logic [16:0] e, input int n);
		int t;
		{instr_op, instr_dst, instr_src, instr_imm, instr_long} =
			{o, dd, ss, im, l};
		instr_valid = 1'b1;
		t = 0;
		do begin
			@(posedge ref_clk);
			t++;
		end while (!instr_ready && t < 50);
		if (!instr_ready) begin
			error_cnt++;
			report_and_stop;
		end
		if (n >= 0) begin
			eq.push_back(e);
			dq.push_back(n > 0 ? cyc + 3 + n : 0);
		end
		#1;
	endtask

	task automatic idle(input int n);
		instr_valid = 1'b0;
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic bit_jump(input op_t o, input logic [15:0] pa,
		input logic t, input logic [15:0] r);
		instr_pc = pa;
		if (t)
			jq.push_back({1'b0, pa + 16'h0040});
		issue(o, 4'h3, 4'h0, pa + 16'h0040, 1'b1, {1'b1, r}, 0);
		idle(8);
	endtask

	// results come off the queues in order of retirement
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		ovc <= ovc + int'(arst_n && stack_overflow_trap);
		unc <= unc + int'(arst_n && stack_underflow_trap);
		if (arst_n && retire) begin
			if (eq.size() == 0)
				check(32'h1, 32'h0);
			else begin
				if (eq[0][16])
					check(result, eq[0][15:0]);
				if (dq[0] != 0)
					check(cyc, dq[0]);
				void'(eq.pop_front());
				void'(dq.pop_front());
			end
		end
		if (arst_n && jump_taken) begin
			if (jq.size() == 0)
				check(32'h1, 32'h0);
			else
				check({jump_cache_hit, jump_target}, jq.pop_front());
		end
	end

	// --------------------
	// scenarios
	// --------------------
	initial begin
		void'($urandom(65));
		repeat (20) @(posedge ref_clk);
		#1 arst_n = 1'b1;
		check(stack_pointer, 16'h0800);
		check(instr_ready, 1'b1);
		for (int i = 0; i < 16; i++) begin
			rf[i] = 16'($urandom);
			issue(op_move, i[3:0], 4'h0, rf[i], 1'b1, {1'b1, rf[i]}, 0);
		end
		idle(8);
		// a bank one word up overlaps the old one
		context_pointer = 16'h0202;
		issue(op_add, 4'h0, 4'h0, 16'h0, 1'b1, {1'b1, rf[1]}, 1);
		idle(8);
		context_pointer = 16'h0200;
		for (int i = 0; i < 14; i++) begin
			d = 4'($urandom);
			s = 4'($urandom);
			w = 16'($urandom);
			instr_step_two = 1'($urandom);
			if (i < 12) begin
				instr_long = ops[i] < op_shift_left && 1'($urandom);
				v = alu(ops[i], rf[d], instr_long ? w : rf[s]);
			end else
				v = rf[d] + (i[0] ? 16'h1 : 16'hFFFF) * (instr_step_two + 16'h1);
			rf[d] = v;
			issue(i < 12 ? ops[i] : i[0] ? op_compare_increment :
				op_compare_decrement, d, s, w, instr_long, {1'b1, v}, 0);
		end
		w = {8'h00, 8'($urandom)} | 16'h0001;
		rf[2] = w;
		issue(op_move, 4'h2, 4'h0, w, 1'b1, {1'b1, w}, 0);
		for (int i = 0; i < 2; i++) begin
			p = 32'h0123 * w;
			issue(op_move, 4'h1, 4'h0, 16'h0123, 1'b1, 17'h10123, 0);
			idle(8);
			issue(i ? op_word_multiply_u : op_word_multiply, 4'h1, 4'h2,
				16'h0, 1'b0, {1'b1, p[15:0]}, 5);
			idle(12);
			check(product_high, p[31:16]);
		end
		issue(op_divide, 4'h1, 4'h2, 16'h0, 1'b0, 17'h10123, 10);
		idle(16);
		check(product_high, 16'h0);
		instr_cond = 1'b1;
		instr_pc = 16'h0100;
		for (int i = 0; i < 2; i++) begin
			jq.push_back({i[0], 16'h0240});
			issue(op_jump, 4'h0, 4'h0, 16'h0240, 1'b1, 17'h0, 2 - i);
			idle(8);
		end
		instr_pc = 16'h0110;
		jq.push_back({1'b0, 16'h0280});
		issue(op_jump, 4'h0, 4'h0, 16'h0280, 1'b1, 17'h0, 2);
		issue(op_add, 4'h9, 4'h9, 16'h0001, 1'b1, 17'h0, -1);
		idle(8);
		instr_cond = 1'b0;
		issue(op_jump, 4'h0, 4'h0, 16'h02C0, 1'b1, 17'h0, 2);
		issue(op_move, 4'h3, 4'h0, 16'h0010, 1'b1, 17'h10010, 0);
		bit_jump(op_jump_clear_bit, 16'h0300, 1'b1, 16'h0);
		bit_jump(op_jump_set_bit, 16'h0310, 1'b1, 16'h0010);
		bit_jump(op_jump_set_bit, 16'h0320, 1'b0, 16'h0010);
		v = rf[5];
		w = rf[6];
		issue(op_context_switch, 4'h5, 4'h0, 16'h1111, 1'b1, 17'h11111, 2);
		idle(8);
		check(stack_pointer, 16'h07FE);
		check(ovc, 0);
		issue(op_context_switch, 4'h6, 4'h0, 16'h2222, 1'b1, 17'h12222, 2);
		idle(8);
		check(stack_pointer, 16'h07FC);
		check(ovc, 1);
		jq.push_back({1'b0, w});
		issue(op_return_and_pop, 4'h7, 4'h0, 16'h0, 1'b0, {1'b1, v}, 2);
		idle(8);
		check(stack_pointer, 16'h0800);
		check(unc, 1);
		k = $urandom % 8;
		issue(op_multiply_accumulate, 4'h1, 4'h2, 16'(k), 1'b0, 17'h0, k + 1);
		idle(16);
		check(pair_cnt_q, 8'(k + 1));
		issue(op_power_down_entry, 4'h0, 4'h0, 16'h0, 1'b1, 17'h0, 0);
		idle(8);
		check(power_down_req, 1'b0);
		nmi_n = 1'b0;
		idle(4);
		issue(op_power_down_entry, 4'h0, 4'h0, 16'h0, 1'b1, 17'h0, 0);
		idle(8);
		check(power_down_req, 1'b1);
		check(eq.size(), 0);
		report_and_stop;
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		report_and_stop;
	end
endmodule
